// File: scc_pkg.sv
// shared constants and types for the successive-approximation conversion control
package scc_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned CLK_NS      = 20;
  localparam int unsigned RESULT_BITS = 12;

  // bit-step rates with the rate-select input grounded
  localparam int unsigned SLOW_RATE_HZ = 600_000;
  localparam int unsigned FAST_RATE_HZ = 1_500_000;
  localparam int unsigned SLOW_STEP_CYC = CLK_HZ / SLOW_RATE_HZ;
  localparam int unsigned FAST_STEP_CYC = CLK_HZ / FAST_RATE_HZ;

  // faster steps when a short conversion is selected
  localparam int unsigned SLOW10_STEP_CYC = 68;
  localparam int unsigned FAST10_STEP_CYC = 27;
  localparam int unsigned SLOW8_STEP_CYC  = 55;
  localparam int unsigned FAST8_STEP_CYC  = 22;

  // clock-out pulse width
  localparam int unsigned PULSE_NS  = 100;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  // start pulse least high time
  localparam int unsigned START_MIN_NS  = 100;
  localparam int unsigned START_MIN_CYC = (START_MIN_NS + CLK_NS - 1) / CLK_NS;

  // full-length conversion ceilings
  localparam int unsigned SLOW_CONV_US = 20;
  localparam int unsigned FAST_CONV_US = 8;

  // buffer settling time
  localparam int unsigned SETTLE_US  = 3;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

  localparam logic [1:0] RATE_NORMAL = 2'h0;
  localparam logic [1:0] RATE_TEN    = 2'h1;
  localparam logic [1:0] RATE_EIGHT  = 2'h2;

  localparam logic [11:0] RESULT_RESET = 12'h0fff;

  typedef enum logic [1:0] {
    SCC_UNIPOLAR,
    SCC_OFFSET_BIN,
    SCC_TWOS_COMP
  } scc_coding_t;

  typedef struct packed {
    logic [11:0] code;
    logic        truncated;
  } scc_result_t;

endpackage : scc_pkg

// File: scc_fifo.sv
// small valid/ready FIFO for result words
`timescale 1ns/1ps
module scc_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;
  assign outData  = mem[rdPtr];

  // storage has no reset, it only holds words counted as valid
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (doWrite && !doRead) begin
      count <= count + 1'b1;
    end else if (doRead && !doWrite) begin
      count <= count - 1'b1;
    end
  end
endmodule : scc_fifo

// File: scc_sar_control.sv
// sequencer, result latch, serial stream and clock-out for a 12-bit SAR converter
`timescale 1ns/1ps
// How it works
// - a conversion starts on the falling edge of start, never the rising edge
// - one comparator decision per step, MSB first, builds a 12-bit result
// - full conversion fits 20us slow model, 8us fast model
// - short-cycled: 15us/6us at 10 bits, 10us/4us at 8 bits
// - parallel result latched, held until the next start arrives
// - parallel result complementary: binary, offset binary or two's complement
// - serial output shows each decision as made, NRZ, MSB first
// - serial stream only complementary binary or offset binary
// - busy high during reset and conversion, low when result complete
// - clock-out pulses about 100ns wide at 600kHz or 1.5MHz with rate select grounded, faster when short-cycled
module scc_sar_control
  import scc_pkg::*;
#(
  parameter bit          FAST_MODEL  = 1'b0,
  parameter int unsigned FIFO_DEPTH  = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        compare,
  input  wire logic        earlyStop,
  input  wire logic [1:0]  rateSelect,
  input  wire scc_coding_t coding,
  output logic [11:0]      dacCode,
  output logic [11:0]      parallelOut,
  output logic             serialOut,
  output logic             busy,
  output logic             clockOut,
  output logic             resultValid,
  input  wire logic        resultReady,
  output scc_result_t      resultData
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RESET,
    ST_DECIDE,
    ST_DONE
  } scc_state_t;

  scc_state_t  state;
  logic        startPrev;
  logic        startFall;
  logic [7:0]  stepCount;
  logic [7:0]  stepLen;
  logic        stepTick;
  logic [3:0]  bitIdx;
  logic [11:0] trial;
  logic [11:0] sar;
  logic [11:0] next_sar;
  logic        decision;
  logic [2:0]  pulseCount;
  logic        fifoReady;
  logic        pushPending;
  scc_result_t pushWord;
  logic [11:0] coded;
  logic [11:0] nextTrialBit;
  logic [10:0] convCycles;

  // longest busy span allowed for a full conversion on this model, in clocks
  localparam int unsigned CONV_LIMIT =
    (FAST_MODEL ? FAST_CONV_US : SLOW_CONV_US) * (CLK_HZ / 1_000_000);

  // falling edge of start begins a conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      startPrev <= 1'b0;
    end else begin
      startPrev <= start;
    end
  end
  assign startFall = startPrev && !start;

  // step length follows model and rate select, faster when short-cycled
  always_comb begin
    unique case (rateSelect)
      RATE_TEN:   stepLen = 8'(FAST_MODEL ? FAST10_STEP_CYC : SLOW10_STEP_CYC);
      RATE_EIGHT: stepLen = 8'(FAST_MODEL ? FAST8_STEP_CYC : SLOW8_STEP_CYC);
      default:    stepLen = 8'(FAST_MODEL ? FAST_STEP_CYC : SLOW_STEP_CYC);
    endcase
  end

  // internal bit clock, restarted at each start so every decision gets a full step
  always_ff @(posedge clk) begin
    if (rst || stepTick || startFall || state == ST_RESET) begin
      stepCount <= '0;
    end else begin
      stepCount <= stepCount + 1'b1;
    end
  end
  assign stepTick = (stepCount >= stepLen - 8'd1);

  // clock-out pulse on each step, fixed width
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseCount <= '0;
    end else if (stepTick) begin
      pulseCount <= 3'(PULSE_CYC);
    end else if (pulseCount != '0) begin
      pulseCount <= pulseCount - 1'b1;
    end
  end
  assign clockOut = (pulseCount != '0);

  // trial code: bits decided so far plus the one under test
  assign trial   = sar | (12'h0800 >> bitIdx);
  assign dacCode = trial;
  // bit that comes under test after the current one, zero past the lsb
  assign nextTrialBit = 12'h0800 >> (bitIdx + 4'd1);
  // comparator high means the trial is below input, keep the bit
  assign decision = compare;
  always_comb begin
    next_sar = sar;
    if (decision) begin
      next_sar = trial;
    end
  end

  // sequencer: a start always restarts, even mid-conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= ST_RESET;
      bitIdx <= '0;
      sar    <= '0;
    end else if (startFall) begin
      state  <= ST_RESET;
      bitIdx <= '0;
      sar    <= '0;
    end else begin
      unique case (state)
        ST_IDLE:  state <= ST_IDLE;
        // clearing takes one clock, not a bit step, so twelve steps fit the time limit
        ST_RESET: state <= ST_DECIDE;
        ST_DECIDE: begin
          // early-stop is watched every clock so a short cycle wastes no step
          if (!earlyStop) begin
            state <= ST_DONE;
          end else if (stepTick) begin
            sar <= next_sar;
            if (bitIdx == 4'd11) begin
              state <= ST_DONE;
            end else begin
              bitIdx <= bitIdx + 4'd1;
            end
          end
        end
        ST_DONE:  state <= ST_IDLE;
      endcase
    end
  end

  // complementary coding of the finished code
  always_comb begin
    unique case (coding)
      SCC_TWOS_COMP: coded = ~{~sar[11], sar[10:0]};
      default:       coded = ~sar;
    endcase
  end

  // parallel outputs: running complement while converting, latched at the end
  always_ff @(posedge clk) begin
    if (rst) begin
      parallelOut <= RESULT_RESET;
    end else if (startFall) begin
      parallelOut <= RESULT_RESET;
    end else if (state == ST_RESET) begin
      parallelOut <= ~12'h0800; // msb shown under test
    end else if (state == ST_DECIDE && earlyStop && stepTick) begin
      // next bit shows low while tested, which is what short-cycle wiring watches
      parallelOut <= ~(next_sar | nextTrialBit);
    end else if (state == ST_DONE) begin
      parallelOut <= coded;
    end
  end

  // serial stream: current decision, complemented, never two's complement
  always_ff @(posedge clk) begin
    if (rst) begin
      serialOut <= 1'b1;
    end else if (state == ST_DECIDE && stepTick && earlyStop) begin
      serialOut <= ~decision;
    end
  end

  // busy high during reset and conversion
  assign busy = (state == ST_RESET) || (state == ST_DECIDE) || (state == ST_DONE);

  // a finished result waits for room; a full FIFO holds the push until a newer result overwrites it
  always_ff @(posedge clk) begin
    if (rst) begin
      pushPending <= 1'b0;
      pushWord    <= '0;
    end else if (state == ST_DONE) begin
      pushPending        <= 1'b1;
      pushWord.code      <= coded;
      pushWord.truncated <= !earlyStop;
    end else if (fifoReady) begin
      pushPending <= 1'b0;
    end
  end

  scc_fifo #(
    .WIDTH ($bits(scc_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushPending),
    .inReady  (fifoReady),
    .inData   (pushWord),
    .outValid (resultValid),
    .outReady (resultReady),
    .outData  (resultData)
  );

  // helper for the time bound: clocks spent busy since the last start
  always_ff @(posedge clk) begin
    if (rst || startFall) begin
      convCycles <= '0;
    end else if (busy && convCycles != '1) begin
      convCycles <= convCycles + 11'd1;
    end
  end

  // checks on the sequencer, result latch, serial stream and clock-out

  a_start_falls: assert property (@(posedge clk) disable iff (rst)
    ($fell(start)) |=> (state == ST_RESET) && busy)
    else $error("falling start did not restart conversion");

  a_rise_ignored: assert property (@(posedge clk) disable iff (rst)
    ($rose(start) && state == ST_IDLE) |=> state == ST_IDLE)
    else $error("rising start began a conversion");

  a_busy_done: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DONE && !startFall) |=> !busy ##0 parallelOut == $past(coded))
    else $error("busy or result wrong after completion");

  a_result_held: assert property (@(posedge clk) disable iff (rst)
    (state == ST_IDLE && !startFall) |=> $stable(parallelOut))
    else $error("parallel result changed while idle");

  a_serial_now: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DECIDE && stepTick && earlyStop && !startFall) |=> serialOut == !$past(compare))
    else $error("serial bit not the current decision");

  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    $rose(clockOut) |-> clockOut [*5] ##1 !clockOut)
    else $error("clock-out pulse width wrong");

  a_busy_state: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DECIDE) |-> busy)
    else $error("busy low during conversion");

  a_full_bits: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DECIDE && earlyStop) |-> bitIdx <= 4'd11)
    else $error("bit index beyond twelve bits");

  a_reset_brief: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RESET && !startFall) |=> state == ST_DECIDE && dacCode == 12'h0800)
    else $error("register clear did not lead to the msb trial");

  a_short_stop: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DECIDE && !earlyStop && !startFall) |=> state == ST_DONE && busy)
    else $error("early stop did not end the conversion");

  a_done_brief: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DONE && !startFall) |=> state == ST_IDLE)
    else $error("done state lasted more than one clock");

  a_serial_hold: assert property (@(posedge clk) disable iff (rst)
    (state == ST_IDLE && !startFall) |=> $stable(serialOut))
    else $error("serial output changed without a decision");

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    stepTick |=> !stepTick [*8])
    else $error("bit steps closer than the clock-out pulse allows");

  a_pulse_start: assert property (@(posedge clk) disable iff (rst)
    stepTick |=> clockOut)
    else $error("clock-out pulse missing on a bit step");

  a_trial_hold: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DECIDE && !stepTick && earlyStop && !startFall) |=> $stable(dacCode))
    else $error("trial code moved inside a bit step");

  a_push_once: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DONE && !startFall) |=> pushPending)
    else $error("finished result not offered to the queue");

  a_conv_limit: assert property (@(posedge clk) disable iff (rst)
    busy |-> convCycles < 11'(CONV_LIMIT))
    else $error("conversion ran past its time limit");

endmodule : scc_sar_control

// File: scc_comparator_model.sv
// comparator stand-in: judges the trial code against a held input level
`timescale 1ns/1ps
module scc_comparator_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [11:0] level,
  input  wire logic [11:0] dacCode,
  output logic             compare
);
  logic now;
  logic lag1;
  logic lag2;
  // keep the trial bit while the trial is not above the level
  assign now = (dacCode <= level);
  // slow mode shows a stale answer for two cycles, like a settling comparator
  always_ff @(posedge clk) begin
    lag1 <= now;
    lag2 <= lag1;
  end
  assign compare = slow ? lag2 : now;
endmodule : scc_comparator_model

// File: scc_sar_control_tb.sv
// self-checking bench for the sar conversion control
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module scc_sar_control_tb;
  import scc_pkg::*;
  logic        clk, rst, start, earlyStop, resultReady, slowCmp, truncOn, compare;
  logic        serialOut, busy, clockOut, resultValid;
  logic [1:0]  rateSelect;
  logic [11:0] target, dacCode, parallelOut;
  int          truncIdx, failures, num_checks;
  scc_coding_t coding;
  scc_result_t resultData;
  logic        serQ[$];
  scc_sar_control #(.FAST_MODEL(1'b1), .FIFO_DEPTH(4)) uut (.clk(clk), .rst(rst),
    .start(start), .compare(compare), .earlyStop(earlyStop), .rateSelect(rateSelect),
    .coding(coding), .dacCode(dacCode), .parallelOut(parallelOut), .serialOut(serialOut),
    .busy(busy), .clockOut(clockOut), .resultValid(resultValid),
    .resultReady(resultReady), .resultData(resultData));
  scc_comparator_model cmp (.clk(clk), .slow(slowCmp), .level(target), .dacCode(dacCode),
    .compare(compare));
  // host ties the short-cycle pin to the bit after the last one wanted
  assign earlyStop = truncOn ? parallelOut[truncIdx] : 1'b1;
  // decisions sampled just after the clock-out rise that marks each step
  always @(posedge clockOut) begin
    #1;
    if (busy === 1'b1) serQ.push_back(serialOut);
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic [11:0] coded(input logic [11:0] t);
    return (coding == SCC_TWOS_COMP) ? (~t ^ 12'h0800) : ~t;
  endfunction : coded
  // one conversion: settle, pulse start, wait for busy low under a limit
  task automatic convert(input logic [11:0] t, input int lim);
    int n;
    target = t;
    serQ.delete();
    cyc(SETTLE_CYC);
    start = 1'b1;
    cyc(START_MIN_CYC);
    start = 1'b0;
    cyc(2);
    `CHK("busy after fall", 1'b1, busy)
    n = 2;
    while (busy !== 1'b0 && n <= lim + 2) begin
      cyc(1);
      n++;
    end
    `CHK("conversion time", 1'b1, n <= lim)
  endtask : convert
  task automatic t_codings();
    for (int c = 0; c < 3; c++) begin
      coding = scc_coding_t'(c);
      convert(12'h05a3, FAST_CONV_US * 50);
      `CHK("parallel result", coded(12'h05a3), parallelOut)
      `CHK("serial count", 1'b1, serQ.size() >= 12)
      for (int i = 0; i < 12 && serQ.size() >= 12; i++)
        `CHK("serial bit", ~target[11-i], serQ[serQ.size()-12+i])
    end
    coding = SCC_UNIPOLAR;
  endtask : t_codings
  task automatic t_rise_hold();
    logic [11:0] held;
    held = parallelOut;
    target = 12'h0c31;
    start = 1'b1;
    cyc(10);
    `CHK("busy on rise", 1'b0, busy)
    `CHK("held result", held, parallelOut)
    start = 1'b0;
    cyc(400);
    `CHK("new result", ~target, parallelOut)
  endtask : t_rise_hold
  task automatic t_short();
    int bits [2] = '{8, 10};
    logic [11:0] mask;
    truncOn = 1'b1;
    for (int k = 0; k < 2; k++) begin
      truncIdx = 11 - bits[k];
      rateSelect = (bits[k] == 8) ? RATE_EIGHT : RATE_TEN;
      convert(12'h0a5c, (bits[k] == 8) ? 200 : 300);
      mask = 12'hfff << (12 - bits[k]);
      `CHK("short result", ~target & mask, parallelOut & mask)
    end
    truncOn = 1'b0;
    rateSelect = RATE_NORMAL;
  endtask : t_short
  task automatic t_clock();
    int hi, per;
    start = 1'b1;
    cyc(START_MIN_CYC);
    start = 1'b0;
    for (int i = 0; i < 10 && clockOut === 1'b1; i++) cyc(1);
    for (int i = 0; i < 100 && clockOut !== 1'b1; i++) cyc(1);
    for (hi = 0; hi < 50 && clockOut === 1'b1; hi++) cyc(1);
    for (per = hi; per < 100 && clockOut !== 1'b1; per++) cyc(1);
    `CHK("clock pulse width", PULSE_CYC, hi)
    `CHK("clock period", FAST_STEP_CYC, per)
    cyc(500);
  endtask : t_clock
  task automatic t_fifo();
    logic [11:0] v [4] = '{12'h0001, 12'h0ffe, 12'h0800, 12'h07ff};
    resultReady = 1'b0;
    slowCmp = 1'b1;
    for (int i = 0; i < 4; i++) convert(v[i], FAST_CONV_US * 50);
    for (int i = 0; i < 4; i++) begin
      `CHK("queued valid", 1'b1, resultValid)
      `CHK("queued word", {~v[i], 1'b0}, resultData)
      resultReady = 1'b1;
      cyc(1);
      resultReady = 1'b0;
      cyc(1);
    end
    `CHK("queue empty", 1'b0, resultValid)
    resultReady = 1'b1;
    slowCmp = 1'b0;
  endtask : t_fifo
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #(60_000 * 20);
    failures++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    target = 12'h0000;
    slowCmp = 1'b0;
    truncOn = 1'b0;
    truncIdx = 0;
    rateSelect = RATE_NORMAL;
    coding = SCC_UNIPOLAR;
    resultReady = 1'b1;
    failures = 0;
    num_checks = 0;
    cyc(10);
    `CHK("reset result", RESULT_RESET, parallelOut)
    `CHK("reset busy", 1'b1, busy)
    rst = 1'b0;
    cyc(600);
    t_codings();
    t_rise_hold();
    t_short();
    t_clock();
    t_fifo();
    end_of_test();
  end
endmodule : scc_sar_control_tb
